// >>> dpsm_map.svh
// dpsm_map.svh - constants for the drive profile state machine.
// Assumes inclusion by the package and the top module by bare name.
`ifndef DPSM_MAP_SVH
`define DPSM_MAP_SVH

// ----------------------------------------------------------------
// object indices
// ----------------------------------------------------------------
`define DPSM_CMD_WORD_INDEX 16'h6040
`define DPSM_STATE_WORD_INDEX 16'h6041
`define DPSM_WORD_RESET 16'h0000

// ----------------------------------------------------------------
// command word bit positions
// ----------------------------------------------------------------
`define DPSM_CW_SWITCH_ON 0
`define DPSM_CW_ENABLE_VOLTAGE 1
`define DPSM_CW_QUICK_STOP 2
`define DPSM_CW_ENABLE_OP 3
`define DPSM_CW_FAULT_RESET 7
`define DPSM_CW_HALT 8
`define DPSM_CW_REMOTE 11

// ----------------------------------------------------------------
// state word bit positions
// ----------------------------------------------------------------
`define DPSM_SW_VOLTAGE 4
`define DPSM_SW_QUICK_STOP 5
`define DPSM_SW_SWON_DISABLED 6
`define DPSM_SW_REMOTE 9
`define DPSM_SW_TARGET 10

// ----------------------------------------------------------------
// state codes in the low nibble
// ----------------------------------------------------------------
`define DPSM_NIB_NONE 4'h0
`define DPSM_NIB_READY 4'h1
`define DPSM_NIB_SWON 4'h3
`define DPSM_NIB_ENABLED 4'h7
`define DPSM_NIB_REACT 4'hF
`define DPSM_NIB_FAULT 4'h8

// ----------------------------------------------------------------
// internal run command word bits
// ----------------------------------------------------------------
`define DPSM_RUN_RAMP 0
`define DPSM_RUN_ENABLE 1

// initialization time after reset
`define DPSM_INIT_NS 1000
`define DPSM_CLK_NS 40
`define DPSM_INIT_CYCLES ((`DPSM_INIT_NS + `DPSM_CLK_NS - 1) / `DPSM_CLK_NS)

`endif

// >>> dpsm_pkg.sv
// dpsm_pkg.sv - types of the drive profile state machine.
// Assumes dpsm_map.svh is on the include path.
package dpsm_pkg;
    `include "dpsm_map.svh"

    // ------------------------------------------------------------
    // drive states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DPSM_NOT_READY,
        DPSM_SWON_DISABLED,
        DPSM_READY,
        DPSM_SWITCHED_ON,
        DPSM_ENABLED,
        DPSM_QUICK_STOP,
        DPSM_FAULT_REACT,
        DPSM_FAULT
    } dpsm_state_t;

    // mode-specific command bits passed on to mode logic
    typedef struct packed {
        logic halt;
        logic bit6;
        logic bit5;
        logic bit4;
    } dpsm_mode_bits_t;

    // drive condition inputs from the inverter
    typedef struct packed {
        logic at_reference;
        logic remote_accept;
        logic halt_active;
    } dpsm_cond_t;
endpackage : dpsm_pkg

// >>> dpsm_core.sv
// dpsm_core.sv - drive profile state machine, control word in, state word out.
// Assumes command word writes arrive as a one-cycle strobe with data on sys_clk_in;
// fault and condition inputs are synchronous to sys_clk_in.
`timescale 1ns/1ps
`include "dpsm_map.svh"

// Functional notes
// - after reset sit in not-ready, then move alone to switch-on disabled
// - state commands decode only from command bits 0,1,2,3,7
// - shutdown: b7=0,b2=1,b1=1,b0=0; transitions 2, 6, 8
// - switch on: b7=0,b3=0,b2..0=111; transition 3, state change only
// - disable voltage: b7=0,b1=0; transitions 7,9,10,12; 12 clears run enable
// - quick stop: b7=0,b2=0,b1=1; transitions 7,10,11; 11 clears ramp start
// - enable operation: b7=0,b3..0=1111; 4 sets enable and ramp, 16 sets ramp
// - disable operation in operation enabled takes transition 5, clears enable
// - shutdown or disable voltage while operating clears run enable
// - fault enters fault reaction, disables inverter, then moves to fault
// - rising edge of bit 7 resets fault, back to switch-on disabled
// - transitions 2,3,6,7,10 leave both run bits unchanged
// - bit 11 picks local or remote; 12-15 maker use, 9-10 reserved
// - bits 4,5,6,8 go to operation mode logic
// - state word bits 3..0 and 6..5 encode the lower states
// - codes for enabled, quick stop, fault reaction and fault
// - state word bit 4 reports power section supplied
// - state word bit 9 mirrors remote acceptance
// - bit 10 set at reference, or while quick stop or halt
// - state word bits 7, 8, 11, 14, 15 read zero
// - power disabled states switch no supply; power stays on
// - state word bits 12 and 13 read zero in velocity mode
module dpsm_core #(
    parameter int unsigned INIT_CYCLES = `DPSM_INIT_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic cmd_write_in,
    input wire logic [15:0] cmd_word_in,
    input wire logic fault_in,
    input wire dpsm_pkg::dpsm_cond_t cond_in,
    output logic [15:0] cmd_word_out,
    output logic [15:0] state_word_out,
    output logic [1:0] internal_run_command_word_out,
    output dpsm_pkg::dpsm_mode_bits_t mode_bits_out,
    output logic remote_select_out
);
    import dpsm_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // two stage release keeps removal of reset clean
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // command word register
    // ------------------------------------------------------------
    logic [15:0] cmd_word;
    logic fault_reset_prev;

    // stored word; bit 7 history gives the edge
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_word <= `DPSM_WORD_RESET;
            fault_reset_prev <= 1'b0;
        end else if (cmd_write_in) begin
            cmd_word <= cmd_word_in;
            fault_reset_prev <= cmd_word[`DPSM_CW_FAULT_RESET];
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire b0 = cmd_word_in[`DPSM_CW_SWITCH_ON];
    wire b1 = cmd_word_in[`DPSM_CW_ENABLE_VOLTAGE];
    wire b2 = cmd_word_in[`DPSM_CW_QUICK_STOP];
    wire b3 = cmd_word_in[`DPSM_CW_ENABLE_OP];
    wire b7 = cmd_word_in[`DPSM_CW_FAULT_RESET];
    wire is_shutdown = cmd_write_in && !b7 && b2 && b1 && !b0;
    // switch on, shared with disable operation
    wire is_switch_on = cmd_write_in && !b7 && !b3 && b2 && b1 && b0;
    wire is_disable_v = cmd_write_in && !b7 && !b1;
    wire is_quick = cmd_write_in && !b7 && !b2 && b1;
    wire is_enable_op = cmd_write_in && !b7 && b3 && b2 && b1 && b0;
    // rising edge against the last written word
    wire is_fault_reset = cmd_write_in && b7 && !cmd_word[`DPSM_CW_FAULT_RESET];

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    dpsm_state_t state;
    dpsm_state_t next_state;
    logic run_enable;
    logic run_ramp;
    logic next_run_enable;
    logic next_run_ramp;
    logic [$clog2(INIT_CYCLES + 1)-1:0] init_count;
    wire init_done = (init_count == ($clog2(INIT_CYCLES + 1))'(INIT_CYCLES));

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            init_count <= '0;
        end else if (!init_done) begin
            init_count <= init_count + 1'b1;
        end
    end

    // transition endpoints; default holds state and run bits
    always_comb begin
        next_state = state;
        next_run_enable = run_enable;
        next_run_ramp = run_ramp;
        unique case (state)
            DPSM_NOT_READY: begin
                if (init_done) begin
                    next_state = DPSM_SWON_DISABLED;
                end
            end
            DPSM_SWON_DISABLED: begin
                if (is_shutdown) begin
                    next_state = DPSM_READY;
                end
            end
            DPSM_READY: begin
                // transitions 3 and 7 keep run bits
                if (is_switch_on) begin
                    next_state = DPSM_SWITCHED_ON;
                end else if (is_disable_v || is_quick) begin
                    next_state = DPSM_SWON_DISABLED;
                end
            end
            DPSM_SWITCHED_ON: begin
                if (is_enable_op) begin
                    next_state = DPSM_ENABLED;
                    next_run_enable = 1'b1;
                    next_run_ramp = 1'b1;
                end else if (is_shutdown) begin
                    next_state = DPSM_READY;
                end else if (is_disable_v || is_quick) begin
                    next_state = DPSM_SWON_DISABLED;
                end
            end
            DPSM_ENABLED: begin
                if (is_switch_on) begin
                    next_state = DPSM_SWITCHED_ON;
                    next_run_enable = 1'b0;
                end else if (is_shutdown) begin
                    next_state = DPSM_READY;
                    next_run_enable = 1'b0;
                end else if (is_disable_v) begin
                    next_state = DPSM_SWON_DISABLED;
                    next_run_enable = 1'b0;
                end else if (is_quick) begin
                    next_state = DPSM_QUICK_STOP;
                    next_run_ramp = 1'b0;
                end
            end
            DPSM_QUICK_STOP: begin
                if (is_enable_op) begin
                    next_state = DPSM_ENABLED;
                    next_run_ramp = 1'b1;
                end else if (is_disable_v) begin
                    next_state = DPSM_SWON_DISABLED;
                    next_run_enable = 1'b0;
                end
            end
            DPSM_FAULT_REACT: begin
                next_state = DPSM_FAULT;
            end
            DPSM_FAULT: begin
                if (is_fault_reset && !fault_in) begin
                    next_state = DPSM_SWON_DISABLED;
                end
            end
        endcase
        // transition 13 from any operating state
        if (fault_in && state != DPSM_NOT_READY && state != DPSM_FAULT_REACT && state != DPSM_FAULT) begin
            next_state = DPSM_FAULT_REACT;
            next_run_enable = 1'b0;
            next_run_ramp = 1'b0;
        end
    end

    // state and run bit registers
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= DPSM_NOT_READY;
            run_enable <= 1'b0;
            run_ramp <= 1'b0;
        end else begin
            state <= next_state;
            run_enable <= next_run_enable;
            run_ramp <= next_run_ramp;
        end
    end

    // ------------------------------------------------------------
    // state word build
    // ------------------------------------------------------------
    logic [3:0] next_nibble;
    logic [1:0] next_b65;

    // state codes; bit 5 is don't-care where not listed, zero here
    always_comb begin
        next_nibble = `DPSM_NIB_NONE;
        next_b65 = 2'b00;
        unique case (next_state)
            DPSM_NOT_READY: next_nibble = `DPSM_NIB_NONE;
            DPSM_SWON_DISABLED: next_b65 = 2'b10;
            DPSM_READY: begin
                next_nibble = `DPSM_NIB_READY;
                next_b65 = 2'b01;
            end
            DPSM_SWITCHED_ON: begin
                next_nibble = `DPSM_NIB_SWON;
                next_b65 = 2'b01;
            end
            DPSM_ENABLED: begin
                next_nibble = `DPSM_NIB_ENABLED;
                next_b65 = 2'b01;
            end
            DPSM_QUICK_STOP: next_nibble = `DPSM_NIB_ENABLED;
            DPSM_FAULT_REACT: next_nibble = `DPSM_NIB_REACT;
            DPSM_FAULT: next_nibble = `DPSM_NIB_FAULT;
        endcase
    end

    // target reached, quick stop or halt
    wire next_target = cond_in.at_reference || (next_state == DPSM_QUICK_STOP) || cond_in.halt_active;
    // unused bits held at zero in the assembly below
    wire [15:0] next_state_word = {
        5'h00,
        next_target,
        cond_in.remote_accept,
        2'b00,
        next_b65,
        1'b1,
        next_nibble
    };
    // bit 4 constant: power section always fed
    // no supply switching in power disabled states

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // pass-through fields from the new word
    wire [15:0] next_cmd_word = cmd_write_in ? cmd_word_in : cmd_word;
    // remote bit mirrored from command word bit 11

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_word_out <= `DPSM_WORD_RESET;
            cmd_word_out <= `DPSM_WORD_RESET;
            internal_run_command_word_out <= 2'b00;
            mode_bits_out <= '0;
            remote_select_out <= 1'b0;
        end else begin
            state_word_out <= next_state_word;
            cmd_word_out <= next_cmd_word;
            internal_run_command_word_out <= {next_run_enable, next_run_ramp};
            mode_bits_out <= {next_cmd_word[`DPSM_CW_HALT], next_cmd_word[6:4]};
            remote_select_out <= next_cmd_word[`DPSM_CW_REMOTE];
        end
    end

    // fault_reset_prev kept only for visibility of edge history
    wire unused_prev = fault_reset_prev;
endmodule : dpsm_core

// >>> dpsm_core_chk.sv
// checker for the drive profile state machine ports
// assumes one clock domain and is bound to every dpsm_core
`timescale 1ns/1ps
module dpsm_core_chk #(
    parameter int unsigned INIT_CYCLES = 25
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic cmd_write_in,
    input wire logic [15:0] cmd_word_in,
    input wire logic fault_in,
    input wire dpsm_pkg::dpsm_cond_t cond_in,
    input wire logic [15:0] cmd_word_out,
    input wire logic [15:0] state_word_out,
    input wire logic [1:0] internal_run_command_word_out,
    input wire dpsm_pkg::dpsm_mode_bits_t mode_bits_out,
    input wire logic remote_select_out
);
    import dpsm_pkg::*;
    logic [1:0] run;
    // short alias keeps the properties readable
    assign run = internal_run_command_word_out;
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    // accepted command word in a given state
    sequence cmd_in(p, s);
        cmd_write_in && !fault_in && {cmd_word_in[7], cmd_word_in[3:0]} == p && state_word_out[6:0] == s;
    endsequence
    // reaction shown first, fault state within a bound
    sequence react_to_fault;
        run == 2'b00 && state_word_out[3:0] == 4'hF ##[1:30] state_word_out[3:0] == 4'h8;
    endsequence
    a_word_echo: assert property (cmd_write_in |=> cmd_word_out == $past(cmd_word_in))
        else $error("command word readback wrong");
    a_power_on: assert property (reset_n_in [*5] |-> state_word_out[4])
        else $error("power supplied flag low");
    a_enable_run: assert property (cmd_in(5'h0F, 7'h33) |=> run == 2'b11 && state_word_out[6:0] == 7'h37)
        else $error("enable operation did not start");
    a_disable_op: assert property (cmd_in(5'h07, 7'h37) |=> !run[1] && state_word_out[6:0] == 7'h33)
        else $error("disable operation did not stop");
    a_quick_ramp: assert property (cmd_write_in && !fault_in && {cmd_word_in[7], cmd_word_in[2:1]} == 3'b001
        && state_word_out[6:0] == 7'h37 |=> run == 2'b10 && state_word_out[6:0] == 7'h17 && state_word_out[10])
        else $error("quick stop reaction wrong");
    a_fault_stop: assert property (fault_in && state_word_out[2] |=> react_to_fault)
        else $error("fault reaction wrong");
    a_run_steady: assert property (!cmd_write_in && !fault_in |=> $stable(run))
        else $error("run bits moved without cause");
    a_deaf_init: assert property (cmd_write_in && state_word_out[6:0] == 7'h10 |=> state_word_out[3:0] == 4'h0)
        else $error("command taken while initializing");
endmodule : dpsm_core_chk

bind dpsm_core dpsm_core_chk #(.INIT_CYCLES(INIT_CYCLES)) i_chk (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cmd_write_in(cmd_write_in),
    .cmd_word_in(cmd_word_in), .fault_in(fault_in), .cond_in(cond_in), .cmd_word_out(cmd_word_out),
    .state_word_out(state_word_out), .internal_run_command_word_out(internal_run_command_word_out),
    .mode_bits_out(mode_bits_out), .remote_select_out(remote_select_out)
);

// >>> dpsm_master_model.sv
// network master model writing the command word
// assumes callers enter write_word away from a clock edge
`timescale 1ns/1ps
module dpsm_master_model (
    input wire logic sys_clk_in,
    output logic cmd_write_out,
    output logic [15:0] cmd_word_out
);
    initial begin
        cmd_write_out = 1'b0;
        cmd_word_out = 16'h0000;
    end
    task automatic write_word(input logic [15:0] w);
        @(posedge sys_clk_in);
        cmd_write_out <= 1'b1;
        cmd_word_out <= w;
        @(posedge sys_clk_in);
        cmd_write_out <= 1'b0;
        // idle bus shows the inverse so stale data cannot pass
        cmd_word_out <= ~w;
    endtask : write_word
endmodule : dpsm_master_model

// >>> drive_profile_state_machine_tb_top.sv
// self-checking bench for dpsm_core against a behavioural model
// assumes the master model drives the command word strobe
`timescale 1ns/1ps
module drive_profile_state_machine_tb_top;
    import dpsm_pkg::*;
    logic sys_clk_in, reset_n_in, cmd_write_in, fault_in, remote_select_out;
    logic [15:0] cmd_word_in, cmd_word_out, state_word_out, w;
    logic [15:0] m_word = 16'h0000;
    logic [1:0] run;
    logic [1:0] m_run = 2'b00;
    logic m_b7 = 1'b0;
    dpsm_cond_t cond_in;
    dpsm_mode_bits_t mode_bits_out;
    logic [6:0] code [8] = '{7'h10, 7'h50, 7'h31, 7'h33, 7'h37, 7'h17, 7'h1F, 7'h18};
    int failures = 0;
    int n_checks = 0;
    int st = 0;
    int i;
    int seed = 32'h58029736;
    // -1 marks a fault pulse
    int plan [$] = '{'h000F, 'h0007, 'h0006, 'h0007, 'h000F, 'h0007, 'h087F, 'h0F0E, 'h0007, 'h000F, 'h0003,
        'h0007, 'h000F, 'h0002, 'h0001, 'h0006, 'h0005, 'h0006, 'h0007, 'h000B, 'h0006, 'h0007, 'h000F, 'hF00D,
        'h0080, 'h0006, 'h0007, 'h000F, -1, 'h000F, 'h0080, 'h0006, 'h0007, 'h000F, 'h0080, -1, 'h0080, 'h0000, 'h0080};

    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // short init count keeps the run brief
    dpsm_core #(.INIT_CYCLES(12)) i_dut (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cmd_write_in(cmd_write_in),
        .cmd_word_in(cmd_word_in), .fault_in(fault_in), .cond_in(cond_in), .cmd_word_out(cmd_word_out),
        .state_word_out(state_word_out), .internal_run_command_word_out(run),
        .mode_bits_out(mode_bits_out), .remote_select_out(remote_select_out)
    );
    dpsm_master_model i_master (.sys_clk_in(sys_clk_in), .cmd_write_out(cmd_write_in), .cmd_word_out(cmd_word_in));

    task automatic conclude;
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_code(input logic [6:0] c);
        for (i = 0; i < 60; i++) begin
            @(negedge sys_clk_in);
            if (state_word_out[6:0] === c) break;
        end
        if (i == 60) begin
            failures++;
            conclude();
        end
    endtask : wait_code

    task automatic expect_all;
        logic [15:0] e;
        e = {5'h00, cond_in.at_reference | cond_in.halt_active | (st == 5), cond_in.remote_accept, 2'b00, code[st]};
        check(state_word_out, e);
        check({14'h0000, run}, {14'h0000, m_run});
        check(cmd_word_out, m_word);
        check({11'h000, remote_select_out, mode_bits_out}, {11'h000, m_word[11], m_word[8], m_word[6:4]});
    endtask : expect_all

    // reference state machine; bit 7 high blocks all state commands
    task automatic model(input logic [15:0] v);
        if (st == 7 && v[7] && !m_b7) st = 1;
        else if (!v[7] && st >= 1 && st <= 5) begin
            if (!v[1]) begin
                if (st >= 4) m_run[1] = 1'b0;
                st = 1;
            end else if (!v[2]) begin
                if (st == 4) m_run[0] = 1'b0;
                st = (st >= 4) ? 5 : 1;
            end else if (!v[0]) begin
                if (st == 4) m_run[1] = 1'b0;
                if (st == 1 || st == 3 || st == 4) st = 2;
            end else if (!v[3]) begin
                if (st == 4) m_run[1] = 1'b0;
                if (st == 2 || st == 4) st = 3;
            end else if (st == 3 || st == 5) begin
                m_run = (st == 3) ? 2'b11 : {m_run[1], 1'b1};
                st = 4;
            end
        end
        m_b7 = v[7];
        m_word = v;
    endtask : model

    task automatic send(input logic [15:0] v);
        @(posedge sys_clk_in);
        cond_in <= (st == 0) ? 3'b000 : 3'($random(seed));
        i_master.write_word(v);
        model(v);
        @(negedge sys_clk_in);
        expect_all();
    endtask : send

    task automatic fault_hit;
        @(posedge sys_clk_in);
        fault_in <= 1'b1;
        @(posedge sys_clk_in);
        fault_in <= 1'b0;
        st = 7;
        m_run = 2'b00;
        wait_code(7'h18);
        expect_all();
    endtask : fault_hit

    initial begin
        reset_n_in = 1'b0;
        fault_in = 1'b0;
        cond_in = 3'b000;
        repeat (4) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        check(state_word_out, 16'h0000);
        @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(negedge sys_clk_in);
        send(16'h0006);
        wait_code(7'h50);
        st = 1;
        expect_all();
        foreach (plan[k]) begin
            if (plan[k] < 0) fault_hit();
            else send(plan[k][15:0]);
        end
        repeat (300) begin
            w = 16'($random(seed));
            w[7] = w[7] & w[12] & w[13];
            if (st == 2 && !w[7] && w[3:0] == 4'hF) w[3] = 1'b0;
            if (st >= 4 && st <= 5 && $random(seed) % 16 == 0) fault_hit();
            else send(w);
        end
        conclude();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        failures++;
        conclude();
    end
endmodule : drive_profile_state_machine_tb_top
